// ---- core/mst_cfg.svh ----
// constants and timing counts for the motor supervisor timebase
//
// Operation
// - Only the power-up clear timer runs from a self-generated 5.8 MHz tick; other logic runs every clk.
// - Speed reference comes from the reference oscillator input, then divided.
// - Two configuration bits select one of four pre-divide ratios.
// - Halving pin low doubles the total divide ratio, live.
// - Codes 00..11 divide by 3072, 4096, 6144, 8192; code 11 default.
// - Lock-timer counter advances once per timer tick while out of lock.
// - Lock-timer count reaching 1023 raises lock timeout to shutdown logic.
// - Clear holds until supply good, clear timer done, pump ready.
// - Power-up clear timer counts 3 ticks of 5.8 MHz divided by 255.
// - Over-current or lock timeout latches clear with gate outputs off.
// - Condition still present after run/stop cycle relatches shutdown.
// - Run/stop high clears lock timer, asserts clear, gates off.
// - Supply undervoltage forces global clear regardless of other inputs.
// - Current sense ignored during a 3.7 us deglitch blanking window.
// - Over-current shutdown turns gates off within 2.5 us.
// - Speed pulse is a latch set by upper, reset by zero comparator.
// - Out of lock when speed pulse is outside +/-5 % of reference.
`ifndef MST_CFG_SVH
`define MST_CFG_SVH

// ----------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------
`define MST_CLK_MHZ 100
`define MST_INT_OSC_KHZ 5800
`define MST_OSC_MOD (`MST_CLK_MHZ * 10)
`define MST_OSC_STEP (`MST_INT_OSC_KHZ / 100)
`define MST_OSC_W 10

// ----------------------------------------------------------------------
// reference divider
// ----------------------------------------------------------------------
`define MST_DIV_W 15
`define MST_PREDIV_UNIT 1024
`define MST_PREDIV_00 3
`define MST_PREDIV_01 4
`define MST_PREDIV_10 6
`define MST_PREDIV_11 8
`define MST_PREDIV_DEFAULT 2'h3
`define MST_LOCK_PCT 5

// ----------------------------------------------------------------------
// supervisory timing
// ----------------------------------------------------------------------
`define MST_LT_MAX 10'h3FF
`define MST_PUC_DIV 255
`define MST_PUC_CYCLES 3
`define MST_DG_NS 3700
`define MST_DG_CYC ((`MST_DG_NS * `MST_CLK_MHZ) / 1000)
`define MST_OCSD_MAX_NS 2500
`define MST_OCSD_CYC ((`MST_OCSD_MAX_NS * `MST_CLK_MHZ) / 1000)

`endif

// ---- core/mst_pkg.sv ----
// types for the motor supervisor timebase
package mst_pkg;

    // raw asynchronous pins, synchronised before use
    typedef struct packed {
        logic supplyGood;
        logic pumpReady;
        logic runStop;
        logic freqHalfSelect;
        logic lockTimerCap;
        logic refOscInput;
        logic overCurrent;
        logic fgUpper;
        logic fgZero;
    } mst_pins_t;

    // supervisory outputs
    typedef struct packed {
        logic internalClear;
        logic gateEnable;
        logic shutdownLatched;
        logic lockTimeout;
        logic outOfLock;
        logic speedPulseOut;
        logic refTick;
    } mst_status_t;

    typedef enum logic [3:0] {
        ST_CLEAR = 4'h1,
        ST_PUC = 4'h2,
        ST_RUN = 4'h4,
        ST_SHUT = 4'h8
    } mst_state_t;

endpackage

// ---- core/mst_supervisor.sv ----
// supervisory and timebase logic of the motor speed controller
`timescale 1ns/10ps
`include "mst_cfg.svh"

module mst_supervisor (
    input wire logic clk,
    input wire logic rst,
    input wire mst_pkg::mst_pins_t pins,
    input wire logic [1:0] preDivCfg,
    output mst_pkg::mst_status_t status
);
    import mst_pkg::*;

    localparam int SW = $bits(mst_pins_t);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] prev_r;
    mst_pins_t syn;
    mst_pins_t old;

    // first stage feeds only the second; prev_r gives edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign syn = mst_pins_t'(sync2_r);
    assign old = mst_pins_t'(prev_r);

    // ------------------------------------------------------------------
    // global clear from undervoltage
    // ------------------------------------------------------------------
    // supply low wipes every state register below except the internal tick accumulator, whatever else is seen
    logic uvClear;
    assign uvClear = ~syn.supplyGood;

    // ------------------------------------------------------------------
    // internal 5.8 MHz tick
    // ------------------------------------------------------------------
    // phase accumulator: average rate is exact, jitter is one clk period
    logic [`MST_OSC_W-1:0] oscAcc_r;
    logic [`MST_OSC_W:0] oscSum;
    logic oscWrap;
    logic oscTick_r;

    assign oscSum = {1'b0, oscAcc_r} + (`MST_OSC_W+1)'(`MST_OSC_STEP);
    assign oscWrap = oscSum >= (`MST_OSC_W+1)'(`MST_OSC_MOD);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscAcc_r <= '0;
            oscTick_r <= 1'b0;
        end else begin
            oscAcc_r <= oscWrap ?
                `MST_OSC_W'(oscSum - (`MST_OSC_W+1)'(`MST_OSC_MOD)) :
                oscSum[`MST_OSC_W-1:0];
            oscTick_r <= oscWrap;
        end
    end

    // ------------------------------------------------------------------
    // reference divider
    // ------------------------------------------------------------------
    logic [`MST_DIV_W-1:0] preMul;
    logic [`MST_DIV_W-1:0] totalDiv;
    logic [`MST_DIV_W-1:0] refCnt_r;
    logic refEdge;
    logic refWrap;
    logic refTick_r;

    // pre-divide ratio times the fixed 1024 stage
    assign preMul = (preDivCfg == 2'h0) ? `MST_DIV_W'(`MST_PREDIV_00) :
                    (preDivCfg == 2'h1) ? `MST_DIV_W'(`MST_PREDIV_01) :
                    (preDivCfg == 2'h2) ? `MST_DIV_W'(`MST_PREDIV_10) :
                    `MST_DIV_W'(`MST_PREDIV_11);
    // halving pin low doubles the ratio, applied on the fly
    assign totalDiv = syn.freqHalfSelect ?
        `MST_DIV_W'(preMul * `MST_PREDIV_UNIT) :
        `MST_DIV_W'(preMul * `MST_PREDIV_UNIT * 2);
    assign refEdge = syn.refOscInput & ~old.refOscInput;
    // >= also catches a count left above a newly shortened ratio
    assign refWrap = refCnt_r >= totalDiv - `MST_DIV_W'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refCnt_r <= '0;
            refTick_r <= 1'b0;
        end else if (uvClear) begin
            refCnt_r <= '0;
            refTick_r <= 1'b0;
        end else begin
            refTick_r <= refEdge & refWrap;
            if (refEdge) begin
                refCnt_r <= refWrap ? '0 : refCnt_r + `MST_DIV_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // speed pulse latch and lock detector
    // ------------------------------------------------------------------
    logic speed_r;
    logic speedRise;
    logic [`MST_DIV_W-1:0] perCnt_r;
    logic [`MST_DIV_W-1:0] lockBand;
    logic [`MST_DIV_W-1:0] lockLo;
    logic [`MST_DIV_W-1:0] lockHi;
    logic perLong;
    logic outOfLock_r;

    assign speedRise = ~speed_r & syn.fgUpper;
    assign lockBand = totalDiv / `MST_DIV_W'(100 / `MST_LOCK_PCT);
    assign lockLo = totalDiv - lockBand;
    assign lockHi = totalDiv + lockBand;
    assign perLong = perCnt_r > lockHi;

    // set wins over reset so a pulse is never swallowed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_r <= 1'b0;
        end else if (uvClear) begin
            speed_r <= 1'b0;
        end else if (syn.fgUpper) begin
            speed_r <= 1'b1;
        end else if (syn.fgZero) begin
            speed_r <= 1'b0;
        end
    end

    // reference oscillator edges counted between speed pulse rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            perCnt_r <= '0;
            outOfLock_r <= 1'b1;
        end else if (uvClear) begin
            perCnt_r <= '0;
            outOfLock_r <= 1'b1;
        end else if (speedRise) begin
            perCnt_r <= '0;
            outOfLock_r <= (perCnt_r < lockLo) | perLong;
        end else begin
            if (refEdge && !perLong) begin
                perCnt_r <= perCnt_r + `MST_DIV_W'(1);
            end
            if (perLong) begin
                outOfLock_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // lock timer
    // ------------------------------------------------------------------
    logic [9:0] ltCnt_r;
    logic ltTick;
    logic ltClear;
    logic lockTimeout;

    assign ltTick = syn.lockTimerCap & ~old.lockTimerCap;
    assign ltClear = uvClear | syn.runStop;
    assign lockTimeout = ltCnt_r == `MST_LT_MAX;

    // in-lock also restarts the count: timeout needs unbroken loss
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ltCnt_r <= '0;
        end else if (ltClear || !outOfLock_r) begin
            ltCnt_r <= '0;
        end else if (ltTick && !lockTimeout) begin
            ltCnt_r <= ltCnt_r + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // over-current deglitch
    // ------------------------------------------------------------------
    localparam int DGW = $clog2(`MST_DG_CYC + 1);
    logic [DGW-1:0] dgCnt_r;
    logic ocQual;

    // a glitch shorter than the window restarts the count
    assign ocQual = dgCnt_r == DGW'(`MST_DG_CYC);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dgCnt_r <= '0;
        end else if (!syn.overCurrent || uvClear) begin
            dgCnt_r <= '0;
        end else if (!ocQual) begin
            dgCnt_r <= dgCnt_r + DGW'(1);
        end
    end

    // ------------------------------------------------------------------
    // power-up clear timer
    // ------------------------------------------------------------------
    logic [7:0] pucDiv_r;
    logic [1:0] pucCnt_r;
    logic pucTick;
    logic pucDone;

    assign pucTick = oscTick_r && pucDiv_r == 8'(`MST_PUC_DIV - 1);
    assign pucDone = pucCnt_r == 2'(`MST_PUC_CYCLES);

    // prescaler restarts with the supply, else the first tick comes early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pucDiv_r <= '0;
        end else if (uvClear) begin
            pucDiv_r <= '0;
        end else if (oscTick_r) begin
            pucDiv_r <= pucTick ? 8'h00 : pucDiv_r + 8'h01;
        end
    end

    // restarts whenever the supply drops out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pucCnt_r <= '0;
        end else if (uvClear) begin
            pucCnt_r <= '0;
        end else if (pucTick && !pucDone) begin
            pucCnt_r <= pucCnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // supervisor state machine
    // ------------------------------------------------------------------
    mst_state_t state_r;
    mst_state_t state_nxt;
    logic fault;

    assign fault = ocQual | lockTimeout;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_CLEAR: begin
                if (syn.supplyGood) begin
                    state_nxt = ST_PUC;
                end
            end
            ST_PUC: begin
                if (pucDone && syn.pumpReady) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault && !syn.runStop) begin
                    state_nxt = ST_SHUT;
                end
            end
            ST_SHUT: begin
                // held until the host raises run/stop
                if (syn.runStop) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_CLEAR;
            end
        endcase
        if (uvClear) begin
            state_nxt = ST_CLEAR;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_CLEAR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // gates drop on the same edge the fault is seen, well inside 2.5 us
    logic runOk;
    logic clear_r;
    logic gate_r;

    assign runOk = state_nxt == ST_RUN && !syn.runStop && syn.pumpReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clear_r <= 1'b1;
            gate_r <= 1'b0;
        end else begin
            clear_r <= state_nxt != ST_RUN || syn.runStop;
            gate_r <= runOk;
        end
    end

    assign status.internalClear = clear_r;
    assign status.gateEnable = gate_r;
    assign status.shutdownLatched = state_r == ST_SHUT;
    assign status.lockTimeout = lockTimeout;
    assign status.outOfLock = outOfLock_r;
    assign status.speedPulseOut = speed_r;
    assign status.refTick = refTick_r;

endmodule

// ---- sim/mst_far_side.sv ----
// far side model: reference clock, lock timer oscillator, tach comparators
`timescale 1ns/10ps

module mst_far_side (
    input wire logic clk,
    input wire logic rst,
    input wire logic ltOn,
    input wire logic fgOn,
    output logic refOsc,
    output logic ltCap,
    output logic fgUp,
    output logic fgZero
);
    logic [2:0] ltDiv_r;
    logic [12:0] fgCnt_r;
    // ----------------------------------------------------------------
    // oscillators
    // ----------------------------------------------------------------
    // external clock on the reference input, one rise every two cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            refOsc <= 1'b0;
        else
            refOsc <= ~refOsc;
    end
    // timer tick every 8 cycles; held low when stopped so no stray rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ltDiv_r <= 3'h0;
        else
            ltDiv_r <= ltOn ? ltDiv_r + 3'h1 : 3'h0;
    end
    assign ltCap = ltOn & ltDiv_r[2];
    // ----------------------------------------------------------------
    // tach comparators, one speed period of 3072 reference rises
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fgCnt_r <= 13'h0;
        else
            fgCnt_r <= (!fgOn || fgCnt_r == 13'h17FF) ? 13'h0 : fgCnt_r + 13'h1;
    end
    assign fgUp = fgOn && fgCnt_r < 13'h0064;
    assign fgZero = fgOn && fgCnt_r >= 13'h0C00 && fgCnt_r < 13'h0C64;
endmodule

// ---- sim/mst_supervisor_sva.sv ----
// concurrent checks on the supervisor ports
`timescale 1ns/10ps

module mst_supervisor_sva (
    input wire logic clk,
    input wire logic rst,
    input wire mst_pkg::mst_pins_t pins,
    input wire logic [1:0] preDivCfg,
    input wire mst_pkg::mst_status_t status
);
    import mst_pkg::*;
    logic [9:0] ocCnt_r;
    logic [9:0] ocCnt_nxt;
    logic [11:0] oolCnt_r;
    logic [11:0] oolCnt_nxt;
    logic oolRun;
    // ----------------------------------------------------------------
    // run lengths, saturating so long faults never wrap to small counts
    // ----------------------------------------------------------------
    assign oolRun = status.outOfLock && !pins.runStop && pins.supplyGood;
    assign ocCnt_nxt = !pins.overCurrent ? 10'h0 : ocCnt_r + {9'h0, ~&ocCnt_r};
    assign oolCnt_nxt = !oolRun ? 12'h0 : oolCnt_r + {11'h0, ~&oolCnt_r};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ocCnt_r <= 10'h0;
            oolCnt_r <= 12'h0;
        end else begin
            ocCnt_r <= ocCnt_nxt;
            oolCnt_r <= oolCnt_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    uvlo_clear_a: assert property (!pins.supplyGood[*4] |->
        status.internalClear && !status.gateEnable)
        else $error("supply low but not cleared");
    stop_clear_a: assert property (pins.runStop[*4] |->
        status.internalClear && !status.gateEnable)
        else $error("run stop high but not cleared");
    gate_clear_a: assert property (status.gateEnable |->
        !status.internalClear) else $error("gates on during clear");
    shut_gate_a: assert property (status.shutdownLatched |=>
        !status.gateEnable) else $error("gates on while shut down");
    oc_blank_a: assert property ($rose(status.shutdownLatched) &&
        !status.lockTimeout |-> ocCnt_r >= 10'h032)
        else $error("over current shut down inside blanking");
    oc_resp_a: assert property (ocCnt_r == 10'h384 |->
        !status.gateEnable) else $error("over current response too slow");
    lt_wait_a: assert property ($rose(status.lockTimeout) |->
        oolCnt_r >= 12'h7D0) else $error("lock timeout came too early");
    lt_shut_a: assert property (status.lockTimeout && status.gateEnable
        |-> ##[0:2] status.shutdownLatched)
        else $error("lock timeout did not shut down");
    fg_set_a: assert property (pins.fgUpper[*4] |->
        status.speedPulseOut) else $error("speed pulse not set");
    fg_reset_a: assert property ((pins.fgZero && !pins.fgUpper)[*4]
        |-> !status.speedPulseOut) else $error("speed pulse not reset");
    tick_pulse_a: assert property (status.refTick |=>
        !status.refTick) else $error("reference tick wider than a cycle");
    cover property ($rose(status.gateEnable));
    cover property ($rose(status.shutdownLatched));
    cover property ($rose(status.lockTimeout));
    cover property ($fell(status.outOfLock));
endmodule

bind mst_supervisor mst_supervisor_sva u_mst_supervisor_sva (
    .clk(clk), .rst(rst), .pins(pins), .preDivCfg(preDivCfg),
    .status(status));

// ---- sim/mst_supervisor_tb.sv ----
// self-checking bench for the motor supervisor timebase
`timescale 1ns/10ps
`define MST_CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    miscompares++; $display("wrong value %s exp %0d got %0d", nm, ex, got); \
    end end

module mst_supervisor_tb;
    import mst_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] preDivCfg = 2'h0;
    logic supplyGood = 1'b0, pumpReady = 1'b0, runStop = 1'b0;
    logic halfSel = 1'b1, overCurrent = 1'b0, ltOn = 1'b0, fgOn = 1'b0;
    logic refOsc, ltCap, fgUp, fgZero;
    mst_status_t status;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    mst_supervisor u_mst_supervisor (.clk(clk), .rst(rst), .preDivCfg(preDivCfg),
        .pins({supplyGood, pumpReady, runStop, halfSel, ltCap, refOsc,
        overCurrent, fgUp, fgZero}), .status(status));
    mst_far_side u_mst_far_side (.clk(clk), .rst(rst), .ltOn(ltOn),
        .fgOn(fgOn), .refOsc(refOsc), .ltCap(ltCap), .fgUp(fgUp),
        .fgZero(fgZero));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait for the gate enable to reach a level
    task automatic wait_gate(input logic v, input int lim, output int n);
        n = 0;
        while (status.gateEnable !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    // cycles between two reference ticks
    task automatic tick_gap(output int n);
        n = 0;
        while (status.refTick !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        n = 1;
        @(posedge clk);
        while (status.refTick !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic power_up;
        int n;
        @(posedge clk);
        supplyGood <= 1'b1;
        pumpReady <= 1'b1;
        ticks(100);
        `MST_CHK("clear held", 1'b1, status.internalClear)
        wait_gate(1'b1, 20000, n);
        `MST_CHK("clear time", 1'b1, n > 12900 && n < 13300)
        `MST_CHK("clear off", 1'b0, status.internalClear)
        $display("power up done");
    endtask
    task automatic ref_and_lock;
        int n;
        @(posedge clk);
        fgOn <= 1'b1;
        tick_gap(n);
        `MST_CHK("div 3072", 6144, n)
        tick_gap(n);
        `MST_CHK("in lock", 1'b0, status.outOfLock)
        halfSel <= 1'b0;
        tick_gap(n);
        `MST_CHK("div 6144", 12288, n)
        `MST_CHK("lost lock", 1'b1, status.outOfLock)
        fgOn <= 1'b0;
        halfSel <= 1'b1;
        preDivCfg <= 2'h1;
        tick_gap(n);
        `MST_CHK("div 4096", 8192, n)
        $display("divider and lock done");
    endtask
    task automatic over_current;
        int n;
        @(posedge clk);
        overCurrent <= 1'b1;
        ticks(100);
        overCurrent <= 1'b0;
        ticks(20);
        `MST_CHK("short fault", 1'b1, status.gateEnable)
        overCurrent <= 1'b1;
        wait_gate(1'b0, 1000, n);
        `MST_CHK("oc response", 1'b1, n >= 370 && n <= 376)
        `MST_CHK("oc latched", 1'b1, status.shutdownLatched)
        runStop <= 1'b1;
        ticks(10);
        `MST_CHK("stop clear", 1'b1, status.internalClear)
        runStop <= 1'b0;
        ticks(10);
        `MST_CHK("relatch", 1'b1, status.shutdownLatched)
        overCurrent <= 1'b0;
        runStop <= 1'b1;
        ticks(10);
        runStop <= 1'b0;
        wait_gate(1'b1, 20000, n);
        `MST_CHK("released", 1'b1, status.gateEnable)
        $display("over current done");
    endtask
    task automatic lock_timeout;
        int n;
        @(posedge clk);
        ltOn <= 1'b1;
        wait_gate(1'b0, 9000, n);
        `MST_CHK("lock time", 1'b1, n > 8150 && n <= 8200)
        `MST_CHK("lock flag", 1'b1, status.lockTimeout)
        `MST_CHK("lock latched", 1'b1, status.shutdownLatched)
        ltOn <= 1'b0;
        runStop <= 1'b1;
        ticks(5);
        `MST_CHK("lock cleared", 1'b0, status.lockTimeout)
        runStop <= 1'b0;
        $display("lock timeout done");
    endtask
    task automatic uvlo;
        int n;
        wait_gate(1'b1, 20000, n);
        `MST_CHK("run again", 1'b1, status.gateEnable)
        // pump loss drops the gates without latching a shutdown
        pumpReady <= 1'b0;
        ticks(4);
        `MST_CHK("pump gates", 1'b0, status.gateEnable)
        `MST_CHK("pump unlatched", 1'b0, status.shutdownLatched)
        pumpReady <= 1'b1;
        wait_gate(1'b1, 20, n);
        `MST_CHK("pump back", 1'b1, status.gateEnable)
        supplyGood <= 1'b0;
        ticks(4);
        `MST_CHK("uvlo clear", 1'b1, status.internalClear)
        `MST_CHK("uvlo gates", 1'b0, status.gateEnable)
        $display("undervoltage done");
    endtask
    // ----------------------------------------------------------------
    // sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        ticks(20);
        rst <= 1'b0;
        power_up();
        ref_and_lock();
        over_current();
        lock_timeout();
        uvlo();
        complete_run();
    end
endmodule
